/* hw/cfg_port.v */
/*
 * configuration port of a two-channel speech compression processor: serial
 * write-only link, channel control and slot registers, strap mode, slot
 * geometry and per-channel slot counters.
 * assumes the serial link pins and the bit clocks/frame syncs are asynchronous
 * to CLK_I; all are double-synchronised before use.
 */
`timescale 1ns/1ps
`include "cfg_port_defs.vh"

module cfg_port #(
    parameter ALGCLR_CYC  = `ALGCLR_CYC,      // cycles an algorithm state clear takes
    parameter RATE_WAIT   = `RATE_HOLD_CYC    // strap rate settle time in cycles
) (
    input  wire        CLK_I,
    input  wire        RSTN_I,
    input  wire        PORT_MODE_STRAP_I,       // high: serial mode, low: strap mode
    input  wire [5:0]  ADDR_STRAP_I,
    input  wire        SERIAL_CLK_I,
    input  wire        CFG_SHIFT_IN_I,
    input  wire        CHIP_SEL_N_I,
    input  wire        SIDE_X_BIT_CLOCK_I,
    input  wire        SIDE_X_FRAME_SYNC_I,
    input  wire        SIDE_Y_BIT_CLOCK_I,
    input  wire        SIDE_Y_FRAME_SYNC_I,
    output reg  [7:0]  X_CONTROL_O,             // effective control byte, channel X
    output reg  [7:0]  Y_CONTROL_O,             // effective control byte, channel Y
    output reg  [1:0]  X_RATE_O,
    output reg  [1:0]  Y_RATE_O,
    output reg  [5:0]  X_IN_SLOT_O,
    output reg  [5:0]  X_OUT_SLOT_O,
    output reg  [5:0]  Y_IN_SLOT_O,
    output reg  [5:0]  Y_OUT_SLOT_O,
    output reg  [3:0]  X_SLOT_WIDTH_O,
    output reg  [6:0]  X_SLOT_COUNT_O,
    output reg  [3:0]  Y_SLOT_WIDTH_O,
    output reg  [6:0]  Y_SLOT_COUNT_O,
    output reg         X_ALGO_CLEAR_O,          // level: algorithm state being cleared
    output reg         Y_ALGO_CLEAR_O,
    output reg         X_IN_ACTIVE_O,           // current slot is the input slot
    output reg         X_OUT_ACTIVE_O,
    output reg         Y_IN_ACTIVE_O,
    output reg         Y_OUT_ACTIVE_O,
    output reg         X_OUT_EN_O,              // serial data output enable, channel X
    output reg         Y_OUT_EN_O,
    output reg         UPDATING_O               // a register write is in progress
);

// ----------------------------------------------------------------
// functions
// ----------------------------------------------------------------
// decode the split rate selector of a control byte
function [1:0] rate_of;
    input [7:0] c;
    reg   [2:0] s;
    begin
        s = {c[`CTL_SEL2_BIT], c[`CTL_SEL1_BIT], c[`CTL_SEL0_BIT]};
        case (s)
            `SEL_32K: rate_of = `RATE_32K;
            `SEL_24K: rate_of = `RATE_24K;
            `SEL_16K: rate_of = `RATE_16K;
            default:  rate_of = `RATE_UNDEF;
        endcase
    end
endfunction

// slot width from direction only; side 0 = input, 1 = output
function [3:0] width_of;
    input [7:0] c;
    input       out_side;
    begin
        // compress: pcm in, compressed out; expand: the reverse
        if (c[`CTL_DIR_BIT] ^ out_side)
            width_of = `WIDTH_PCM;
        else
            width_of = `WIDTH_CMP;
    end
endfunction

// slot count from direction and law only
function [6:0] count_of;
    input [7:0] c;
    input       out_side;
    begin
        if (c[`CTL_DIR_BIT] ^ out_side)
            count_of = c[`CTL_LAW_BIT] ? `COUNT_MULAW_PCM : `COUNT_ALAW_PCM;
        else
            count_of = c[`CTL_LAW_BIT] ? `COUNT_MULAW_CMP : `COUNT_ALAW_CMP;
    end
endfunction

// ----------------------------------------------------------------
// synchronisers
// ----------------------------------------------------------------
reg [7:0] sync_a;                 // first stage, read only by sync_b
reg [7:0] sync_b;                 // usable synchronised inputs
reg [5:0] addr_a;
reg [5:0] addr_b;
// two flops on every asynchronous input; no reset, so pins are valid at release
always @(posedge CLK_I) begin
    sync_a <= {PORT_MODE_STRAP_I, SERIAL_CLK_I, CFG_SHIFT_IN_I, ~CHIP_SEL_N_I,
               SIDE_X_BIT_CLOCK_I, SIDE_X_FRAME_SYNC_I, SIDE_Y_BIT_CLOCK_I,
               SIDE_Y_FRAME_SYNC_I};
    sync_b <= sync_a;
    addr_a <= ADDR_STRAP_I;
    addr_b <= addr_a;
end
wire serial_mode = sync_b[7];
wire sclk_s      = sync_b[6];
wire sdi_s       = sync_b[5];
wire sel_s       = sync_b[4];     // chip select, active high here
wire xclk_s      = sync_b[3];
wire xfs_s       = sync_b[2];
wire yclk_s      = sync_b[1];
wire yfs_s       = sync_b[0];

// ----------------------------------------------------------------
// serial receiver
// ----------------------------------------------------------------
localparam ST_CMD  = 2'h0;        // awaiting command byte
localparam ST_CTL  = 2'h1;        // awaiting control byte
localparam ST_IN   = 2'h2;        // awaiting input slot byte
localparam ST_OUT  = 2'h3;        // awaiting output slot byte
reg       sclk_d;                 // previous serial clock
reg [1:0] state;
reg [2:0] bit_cnt;
reg [7:0] shift;
reg       matched;                // address matched this write
reg       chan_x;                 // target channel of this write
reg [7:0] ctl_x;                  // stored control bytes
reg [7:0] ctl_y;
reg [5:0] in_x;                   // stored slot numbers
reg [5:0] out_x;
reg [5:0] in_y;
reg [5:0] out_y;
reg [7:0] clr_cnt_x;              // algorithm clear timers
reg [7:0] clr_cnt_y;
wire       sclk_rise = sclk_s & ~sclk_d;
wire [7:0] next_shift = {sdi_s, shift[7:1]};
wire       byte_done  = sel_s & sclk_rise & (bit_cnt == 3'h7);
// shift bits on serial clock rise while selected, dispatch whole bytes
always @(posedge CLK_I) begin
    if (!RSTN_I) begin
        sclk_d  <= 1'b0;
        state   <= ST_CMD;
        bit_cnt <= 3'h0;
        shift   <= 8'h00;
        matched <= 1'b0;
        chan_x  <= 1'b0;
        ctl_x   <= `CTL_RESET;
        ctl_y   <= `CTL_RESET;
        in_x    <= `SLOT_RESET;
        out_x   <= `SLOT_RESET;
        in_y    <= `SLOT_RESET;
        out_y   <= `SLOT_RESET;
    end else if (!serial_mode) begin
        // port disabled, all register bits cleared
        sclk_d  <= 1'b0;
        state   <= ST_CMD;
        bit_cnt <= 3'h0;
        shift   <= 8'h00;
        matched <= 1'b0;
        chan_x  <= 1'b0;
        ctl_x   <= 8'h00;
        ctl_y   <= 8'h00;
        in_x    <= 6'h00;
        out_x   <= 6'h00;
        in_y    <= 6'h00;
        out_y   <= 6'h00;
    end else begin
        sclk_d <= sclk_s;
        if (!sel_s) begin
            // select released: partial byte dropped, next write restarts
            state   <= ST_CMD;
            bit_cnt <= 3'h0;
        end else if (sclk_rise) begin
            shift   <= next_shift;
            bit_cnt <= bit_cnt + 3'h1;
        end
        if (byte_done) begin
            case (state)
                ST_CMD: begin
                    matched <= (next_shift[5:0] == addr_b);
                    chan_x  <= next_shift[`CMD_CHAN_BIT];
                    state   <= ST_CTL;
                end
                ST_CTL: begin
                    if (matched && chan_x)
                        ctl_x <= next_shift;
                    if (matched && !chan_x)
                        ctl_y <= next_shift;
                    state <= ST_IN;
                end
                ST_IN: begin
                    if (matched && chan_x)
                        in_x <= next_shift[5:0];
                    if (matched && !chan_x)
                        in_y <= next_shift[5:0];
                    state <= ST_OUT;
                end
                default: begin
                    if (matched && chan_x)
                        out_x <= next_shift[5:0];
                    if (matched && !chan_x)
                        out_y <= next_shift[5:0];
                    state <= ST_CMD;
                end
            endcase
        end
        // hardware clears the algorithm bit once the clear has run
        if (clr_cnt_x == 8'h01 && !(byte_done && state == ST_CTL && matched && chan_x))
            ctl_x[`CTL_ALGCLR_BIT] <= 1'b0;
        if (clr_cnt_y == 8'h01 && !(byte_done && state == ST_CTL && matched && !chan_x))
            ctl_y[`CTL_ALGCLR_BIT] <= 1'b0;
    end
end

// ----------------------------------------------------------------
// algorithm state clear timers
// ----------------------------------------------------------------
// run while the clear bit stands, then release it
always @(posedge CLK_I) begin
    if (!RSTN_I) begin
        clr_cnt_x <= 8'h00;
        clr_cnt_y <= 8'h00;
    end else begin
        if (ctl_x[`CTL_ALGCLR_BIT] && clr_cnt_x == 8'h00)
            clr_cnt_x <= ALGCLR_CYC[7:0];
        else if (clr_cnt_x != 8'h00)
            clr_cnt_x <= clr_cnt_x - 8'h01;
        if (ctl_y[`CTL_ALGCLR_BIT] && clr_cnt_y == 8'h00)
            clr_cnt_y <= ALGCLR_CYC[7:0];
        else if (clr_cnt_y != 8'h00)
            clr_cnt_y <= clr_cnt_y - 8'h01;
    end
end

// ----------------------------------------------------------------
// strap mode rate capture
// ----------------------------------------------------------------
reg [12:0] rate_wait;             // cycles since reset release
reg        rate_low_seen;         // rate straps were low at release
reg        strap_24k;             // straps raised late: 24 kbps
// the 24k code is both rate straps low at reset, then high after the wait
always @(posedge CLK_I) begin
    if (!RSTN_I) begin
        rate_wait     <= 13'h0000;
        rate_low_seen <= 1'b0;
        strap_24k     <= 1'b0;
    end else begin
        if (rate_wait != 13'h1FFF)
            rate_wait <= rate_wait + 13'h0001;
        if (rate_wait == 13'h0000)
            rate_low_seen <= ~addr_b[1] & ~addr_b[4];
        if (rate_low_seen && addr_b[1] && addr_b[4] && rate_wait >= RATE_WAIT[12:0])
            strap_24k <= 1'b1;
        if (!addr_b[1] || !addr_b[4])
            strap_24k <= 1'b0;
    end
end

// strap-built control bytes; serial clock is assumed held low here
wire [2:0] strap_sel = strap_24k ? `SEL_24K :
                       (addr_b[1] & addr_b[4]) ? `SEL_16K : `SEL_32K;
wire       cs_idle     = ~sel_s;  // chip-select pin high idles X
wire [7:0] strap_ctl_x = {strap_sel[0], strap_sel[1], cs_idle, 1'b0, 1'b0,
                          addr_b[2], strap_sel[2], addr_b[0]};
wire [7:0] strap_ctl_y = {strap_sel[0], strap_sel[1], sdi_s, 1'b0, 1'b0,
                          addr_b[5], strap_sel[2], addr_b[3]};
wire [7:0] eff_x = serial_mode ? ctl_x : strap_ctl_x;
wire [7:0] eff_y = serial_mode ? ctl_y : strap_ctl_y;

// ----------------------------------------------------------------
// slot counters
// ----------------------------------------------------------------
reg       xclk_d;
reg       yclk_d;
reg       xarm;                   // frame sync seen, await next rise
reg       yarm;
reg [8:0] xbit;                   // bit position in frame
reg [8:0] ybit;
// restart the bit count on the first clock rise after frame sync
always @(posedge CLK_I) begin
    if (!RSTN_I) begin
        xclk_d <= 1'b0;
        yclk_d <= 1'b0;
        xarm   <= 1'b0;
        yarm   <= 1'b0;
        xbit   <= 9'h000;
        ybit   <= 9'h000;
    end else begin
        xclk_d <= xclk_s;
        yclk_d <= yclk_s;
        if (xfs_s)
            xarm <= 1'b1;
        else if (xclk_s && !xclk_d) begin
            xarm <= 1'b0;
            xbit <= xarm ? 9'h000 : xbit + 9'h001;
        end
        if (yfs_s)
            yarm <= 1'b1;
        else if (yclk_s && !yclk_d) begin
            yarm <= 1'b0;
            ybit <= yarm ? 9'h000 : ybit + 9'h001;
        end
    end
end

// slot index is the bit count divided by the slot width
wire [8:0] x_in_idx  = eff_x[`CTL_DIR_BIT] ? {3'h0, xbit[8:3]} : {2'h0, xbit[8:2]};
wire [8:0] x_out_idx = eff_x[`CTL_DIR_BIT] ? {2'h0, xbit[8:2]} : {3'h0, xbit[8:3]};
wire [8:0] y_in_idx  = eff_y[`CTL_DIR_BIT] ? {3'h0, ybit[8:3]} : {2'h0, ybit[8:2]};
wire [8:0] y_out_idx = eff_y[`CTL_DIR_BIT] ? {2'h0, ybit[8:2]} : {3'h0, ybit[8:3]};

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
// register every output; strap mode forces slot zero
always @(posedge CLK_I) begin
    if (!RSTN_I) begin
        X_CONTROL_O    <= `CTL_RESET;
        Y_CONTROL_O    <= `CTL_RESET;
        X_RATE_O       <= `RATE_32K;
        Y_RATE_O       <= `RATE_32K;
        X_IN_SLOT_O    <= 6'h00;
        X_OUT_SLOT_O   <= 6'h00;
        Y_IN_SLOT_O    <= 6'h00;
        Y_OUT_SLOT_O   <= 6'h00;
        X_SLOT_WIDTH_O <= `WIDTH_CMP;
        X_SLOT_COUNT_O <= `COUNT_ALAW_CMP;
        Y_SLOT_WIDTH_O <= `WIDTH_CMP;
        Y_SLOT_COUNT_O <= `COUNT_ALAW_CMP;
        X_ALGO_CLEAR_O <= 1'b0;
        Y_ALGO_CLEAR_O <= 1'b0;
        X_IN_ACTIVE_O  <= 1'b0;
        X_OUT_ACTIVE_O <= 1'b0;
        Y_IN_ACTIVE_O  <= 1'b0;
        Y_OUT_ACTIVE_O <= 1'b0;
        X_OUT_EN_O     <= 1'b0;
        Y_OUT_EN_O     <= 1'b0;
        UPDATING_O     <= 1'b0;
    end else begin
        X_CONTROL_O    <= eff_x;
        Y_CONTROL_O    <= eff_y;
        X_RATE_O       <= rate_of(eff_x);
        Y_RATE_O       <= rate_of(eff_y);
        X_IN_SLOT_O    <= serial_mode ? in_x : 6'h00;
        X_OUT_SLOT_O   <= serial_mode ? out_x : 6'h00;
        Y_IN_SLOT_O    <= serial_mode ? in_y : 6'h00;
        Y_OUT_SLOT_O   <= serial_mode ? out_y : 6'h00;
        X_SLOT_WIDTH_O <= width_of(eff_x, 1'b0);
        X_SLOT_COUNT_O <= count_of(eff_x, 1'b0);
        Y_SLOT_WIDTH_O <= width_of(eff_y, 1'b0);
        Y_SLOT_COUNT_O <= count_of(eff_y, 1'b0);
        X_ALGO_CLEAR_O <= eff_x[`CTL_ALGCLR_BIT];
        Y_ALGO_CLEAR_O <= eff_y[`CTL_ALGCLR_BIT];
        X_IN_ACTIVE_O  <= ~eff_x[`CTL_IDLE_BIT] & (x_in_idx[5:0] == X_IN_SLOT_O) & (x_in_idx[8:6] == 3'h0);
        X_OUT_ACTIVE_O <= ~eff_x[`CTL_IDLE_BIT] & (x_out_idx[5:0] == X_OUT_SLOT_O) & (x_out_idx[8:6] == 3'h0);
        Y_IN_ACTIVE_O  <= ~eff_y[`CTL_IDLE_BIT] & (y_in_idx[5:0] == Y_IN_SLOT_O) & (y_in_idx[8:6] == 3'h0);
        Y_OUT_ACTIVE_O <= ~eff_y[`CTL_IDLE_BIT] & (y_out_idx[5:0] == Y_OUT_SLOT_O) & (y_out_idx[8:6] == 3'h0);
        // idle or mid-update outputs float
        X_OUT_EN_O     <= ~eff_x[`CTL_IDLE_BIT] & ~(serial_mode & sel_s);
        Y_OUT_EN_O     <= ~eff_y[`CTL_IDLE_BIT] & ~(serial_mode & sel_s);
        UPDATING_O     <= serial_mode & sel_s;
    end
end

endmodule // cfg_port

/* hw/cfg_port_defs.vh */
/*
 * constants for the channel configuration port: field positions of the
 * command, control and slot bytes, rate codes, slot geometry and timing.
 * assumes it is included by bare name from the design file.
 */
`ifndef CFG_PORT_DEFS_VH
`define CFG_PORT_DEFS_VH
// ----------------------------------------------------------------
// byte fields
// ----------------------------------------------------------------
`define CMD_CHAN_BIT     6
`define CMD_RSVD_BIT     7
`define CTL_SEL0_BIT     7
`define CTL_SEL1_BIT     6
`define CTL_IDLE_BIT     5
`define CTL_ALGCLR_BIT   4
`define CTL_PASS_BIT     3
`define CTL_LAW_BIT      2
`define CTL_SEL2_BIT     1
`define CTL_DIR_BIT      0
`define CTL_RESET        8'h20
`define SLOT_RESET       6'h00
// ----------------------------------------------------------------
// rate codes (bit2, bit1, bit0) and decoded rates
// ----------------------------------------------------------------
`define SEL_32K          3'h0
`define SEL_24K          3'h7
`define SEL_16K          3'h5
`define RATE_32K         2'h0
`define RATE_24K         2'h1
`define RATE_16K         2'h2
`define RATE_UNDEF       2'h3
// ----------------------------------------------------------------
// slot geometry
// ----------------------------------------------------------------
`define WIDTH_PCM        4'h8
`define WIDTH_CMP        4'h4
`define COUNT_MULAW_PCM  7'h20
`define COUNT_ALAW_PCM   7'h20
`define COUNT_MULAW_CMP  7'h40
`define COUNT_ALAW_CMP   7'h40
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS    5000
`define RATE_HOLD_NS     3000
`define RATE_HOLD_CYC    ((`RATE_HOLD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ALGCLR_CYC       16
`endif

/* tb/cfg_host_model.sv */
/* host side of the three-wire write-only configuration link.
   assumes its caller sequences frames; the link clock runs only inside frames. */
`timescale 1ns/1ps
module cfg_host_model (
    output logic serial_clk,
    output logic shift_in,
    output logic chip_sel_n
);
    localparam time HALF = 24ns;  // half of a 48 ns link clock
    initial begin
        serial_clk = 1'b0;
        shift_in   = 1'b1;
        chip_sel_n = 1'b1;
    end
    // select the device, then give it time to see the select
    task automatic open_frame();
        chip_sel_n = 1'b0;
        #(HALF);
    endtask
    // shift bits least significant first; the device takes them on the rise
    task automatic put_byte(input logic [7:0] b, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            shift_in = b[i];
            #(HALF);
            serial_clk = 1'b1;
            #(HALF);
            serial_clk = 1'b0;
        end
    endtask
    // deselect; the data line no longer holds the last bit
    task automatic close_frame();
        #(HALF);
        chip_sel_n = 1'b1;
        shift_in   = ~shift_in;
        #(HALF);
    endtask
    // strap mode: select and data become idle straps, clock held low
    task automatic set_straps(input logic cs_lvl, input logic sdi_lvl);
        serial_clk = 1'b0;
        chip_sel_n = cs_lvl;
        shift_in   = sdi_lvl;
    endtask
endmodule // cfg_host_model

/* tb/cfg_port_monitor.sv */
/* checker for the configuration port: rate decode, slot geometry, output
   enables, strap mode and algorithm clear timing.
   assumes it is bound onto cfg_port and sees only that module's ports. */
`timescale 1ns/1ps
module cfg_port_monitor #(
    parameter ALGCLR_CYC = 16,
    parameter RATE_WAIT  = 600
) (
    input wire       CLK_I,
    input wire       RSTN_I,
    input wire       PORT_MODE_STRAP_I,
    input wire [5:0] ADDR_STRAP_I,
    input wire       CFG_SHIFT_IN_I,
    input wire       CHIP_SEL_N_I,
    input wire [7:0] X_CONTROL_O,
    input wire [7:0] Y_CONTROL_O,
    input wire [1:0] X_RATE_O,
    input wire [5:0] X_IN_SLOT_O,
    input wire [5:0] Y_OUT_SLOT_O,
    input wire [3:0] X_SLOT_WIDTH_O,
    input wire [6:0] X_SLOT_COUNT_O,
    input wire       X_ALGO_CLEAR_O,
    input wire       X_OUT_EN_O,
    input wire       Y_OUT_EN_O,
    input wire       UPDATING_O
);
    localparam int CLR_MAX = ALGCLR_CYC + 4;  // longest wait for a clear to finish
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // -------------------------------------------
    // helpers
    // -------------------------------------------
    // selector bits sit at 1 (bit2), 6 (bit1), 7 (bit0)
    function automatic logic [1:0] rate_of(input logic [7:0] c);
        case ({c[1], c[6], c[7]})
            3'h0: rate_of = 2'h0;
            3'h7: rate_of = 2'h1;
            3'h5: rate_of = 2'h2;
            default: rate_of = 2'h3;
        endcase
    endfunction
    // strap mode with every strap pin quiet for eight cycles
    sequence s_strap_quiet;
        (!PORT_MODE_STRAP_I && $stable(ADDR_STRAP_I) && $stable(CHIP_SEL_N_I) && $stable(CFG_SHIFT_IN_I)) [*8];
    endsequence
    // control byte settled for three cycles
    sequence s_ctl_settled;
        $stable(X_CONTROL_O) [*3];
    endsequence
    // -------------------------------------------
    // assertions
    // -------------------------------------------
    a_rate_decode: assert property ((s_ctl_settled and PORT_MODE_STRAP_I [*3]) |->
        X_RATE_O == rate_of(X_CONTROL_O))
        else $error("rate does not follow selector");
    a_slot_width: assert property (s_ctl_settled |-> X_SLOT_WIDTH_O == (X_CONTROL_O[0] ? 4'h8 : 4'h4))
        else $error("slot width wrong for direction");
    a_slot_count: assert property (s_ctl_settled |-> X_SLOT_COUNT_O == (X_CONTROL_O[0] ? 7'h20 : 7'h40))
        else $error("slot count wrong for direction and law");
    a_idle_tristate: assert property (X_CONTROL_O[5] [*3] |-> !X_OUT_EN_O)
        else $error("idle channel still drives");
    a_update_quiet: assert property (UPDATING_O [*2] |-> !X_OUT_EN_O && !Y_OUT_EN_O)
        else $error("output driven during update");
    a_strap_slots: assert property (s_strap_quiet |-> X_IN_SLOT_O == 6'h00 && Y_OUT_SLOT_O == 6'h00)
        else $error("strap mode slot not zero");
    a_strap_map: assert property (s_strap_quiet |-> X_CONTROL_O[0] == ADDR_STRAP_I[0] && X_CONTROL_O[2] ==
        ADDR_STRAP_I[2] && Y_CONTROL_O[0] == ADDR_STRAP_I[3] && Y_CONTROL_O[2] == ADDR_STRAP_I[5])
        else $error("strap direction or law not mapped");
    a_strap_idle: assert property (s_strap_quiet |-> X_CONTROL_O[5] == CHIP_SEL_N_I && Y_CONTROL_O[5] == CFG_SHIFT_IN_I)
        else $error("strap idle pins not mapped");
    a_strap_noport: assert property (s_strap_quiet |-> !UPDATING_O)
        else $error("serial port active in strap mode");
    a_clear_ends: assert property ($rose(X_ALGO_CLEAR_O) |-> ##[1:CLR_MAX] !X_ALGO_CLEAR_O)
        else $error("algorithm clear never ends");
endmodule // cfg_port_monitor

bind cfg_port cfg_port_monitor #(.ALGCLR_CYC(ALGCLR_CYC), .RATE_WAIT(RATE_WAIT)) cfg_port_monitor_i (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .PORT_MODE_STRAP_I(PORT_MODE_STRAP_I), .ADDR_STRAP_I(ADDR_STRAP_I),
    .CFG_SHIFT_IN_I(CFG_SHIFT_IN_I), .CHIP_SEL_N_I(CHIP_SEL_N_I), .X_CONTROL_O(X_CONTROL_O),
    .Y_CONTROL_O(Y_CONTROL_O), .X_RATE_O(X_RATE_O), .X_IN_SLOT_O(X_IN_SLOT_O), .Y_OUT_SLOT_O(Y_OUT_SLOT_O),
    .X_SLOT_WIDTH_O(X_SLOT_WIDTH_O), .X_SLOT_COUNT_O(X_SLOT_COUNT_O), .X_ALGO_CLEAR_O(X_ALGO_CLEAR_O),
    .X_OUT_EN_O(X_OUT_EN_O), .Y_OUT_EN_O(Y_OUT_EN_O), .UPDATING_O(UPDATING_O));

/* tb/test_cfg_port.sv */
/* self-checking bench for the configuration port: serial writes, refusals,
   algorithm clear and strap mode. assumes the checker is bound separately. */
`timescale 1ns/1ps
module test_cfg_port;
    logic clk = 1'b0, rstn = 1'b0, mode = 1'b1, clr_seen = 1'b0, xbc = 1'b0, xfs = 1'b0;
    logic [5:0] straps = 6'h00, own;
    wire sclk, cfg_shift_in, cs_n, xclr, uo, xia;
    wire [7:0] xc, yc;
    wire [1:0] xr, yr;
    wire [5:0] xi, xo, yi, yo;
    wire [3:0] xw, yw;
    wire [6:0] xn, yn;
    logic [7:0] ctl [2];  // index 1 is channel X
    logic [5:0] sin [2], sout [2];
    logic [65:0] notes [$];
    event result_ev;
    int checks = 0, mismatches = 0;
    logic [2:0] codes [4] = '{3'h0, 3'h7, 3'h5, 3'h3};
    always #2.5 clk = ~clk;
    cfg_host_model cfg_host_model_i (.serial_clk(sclk), .shift_in(cfg_shift_in), .chip_sel_n(cs_n));
    cfg_port #(.ALGCLR_CYC(4), .RATE_WAIT(8)) cfg_port_i (
        .CLK_I(clk), .RSTN_I(rstn), .PORT_MODE_STRAP_I(mode), .ADDR_STRAP_I(straps), .SERIAL_CLK_I(sclk),
        .CFG_SHIFT_IN_I(cfg_shift_in), .CHIP_SEL_N_I(cs_n), .SIDE_X_BIT_CLOCK_I(xbc), .SIDE_X_FRAME_SYNC_I(xfs),
        .SIDE_Y_BIT_CLOCK_I(1'b0), .SIDE_Y_FRAME_SYNC_I(1'b0), .X_CONTROL_O(xc), .Y_CONTROL_O(yc),
        .X_RATE_O(xr), .Y_RATE_O(yr), .X_IN_SLOT_O(xi), .X_OUT_SLOT_O(xo), .Y_IN_SLOT_O(yi),
        .Y_OUT_SLOT_O(yo), .X_SLOT_WIDTH_O(xw), .X_SLOT_COUNT_O(xn), .Y_SLOT_WIDTH_O(yw),
        .Y_SLOT_COUNT_O(yn), .X_ALGO_CLEAR_O(xclr), .Y_ALGO_CLEAR_O(), .X_IN_ACTIVE_O(xia), .X_OUT_ACTIVE_O(),
        .Y_IN_ACTIVE_O(), .Y_OUT_ACTIVE_O(), .X_OUT_EN_O(), .Y_OUT_EN_O(), .UPDATING_O(uo));
    // remember any channel X algorithm clear pulse
    always @(posedge clk) if (xclr === 1'b1) clr_seen <= 1'b1;
    // expected channel state: control, rate, slots, width, count
    function automatic logic [32:0] expect_of(input logic [7:0] c, input logic [5:0] si, input logic [5:0] so);
        logic [1:0] r;
        case ({c[1], c[6], c[7]})
            3'h0: r = 2'h0;
            3'h7: r = 2'h1;
            3'h5: r = 2'h2;
            default: r = 2'h3;
        endcase
        expect_of = {c, r, si, so, c[0] ? 4'h8 : 4'h4, c[0] ? 7'h20 : 7'h40};
    endfunction
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // note the expected state, let outputs settle, then hand over
    task automatic push_note();
        notes.push_back({expect_of(ctl[1], sin[1], sout[1]), expect_of(ctl[0], sin[0], sout[0])});
        repeat (14) @(posedge clk);
        #1 -> result_ev;
        #1;
    endtask
    // compare the oldest note with what the outputs show
    initial forever begin
        logic [65:0] n;
        @(result_ev);
        n = notes.pop_front();
        check("x state", {xc, xr, xi, xo, xw, xn}, n[65:33]);
        check("y state", {yc, yr, yi, yo, yw, yn}, n[32:0]);
    end
    // one serial write; ctl_bits below eight cuts the control byte short
    task automatic write_cfg(input logic to_x, input logic [5:0] addr, input logic [7:0] c,
                             input logic [5:0] si, input logic [5:0] so, input logic four, input int ctl_bits);
        cfg_host_model_i.open_frame();
        cfg_host_model_i.put_byte({1'b0, to_x, addr}, 8);
        cfg_host_model_i.put_byte(c, ctl_bits);
        if (four) begin
            cfg_host_model_i.put_byte({2'b00, si}, 8);
            cfg_host_model_i.put_byte({2'b00, so}, 8);
        end
        cfg_host_model_i.close_frame();
        if (addr == own && ctl_bits == 8) begin
            ctl[to_x] = c & 8'hEF;
            if (four) {sin[to_x], sout[to_x]} = {si, so};
        end
        push_note();
    endtask
    task automatic close_out();
        $display("counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] c;
        logic cs, dl;
        int hit;
        void'($urandom(4558));
        own = 6'($urandom);
        straps = own;
        ctl = '{8'h20, 8'h20};
        sin = '{6'h00, 6'h00};
        sout = '{6'h00, 6'h00};
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        push_note();
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            c = 8'($urandom) & 8'hEF;
            {c[1], c[6], c[7]} = codes[i % 4];
            write_cfg(i[0], own, c, 6'($urandom), 6'($urandom), i < 6, 8);
        end
        $display("test serial writes done");
        write_cfg(1'b1, own ^ 6'h21, 8'h8C, 6'h11, 6'h22, 1'b1, 8);
        write_cfg(1'b0, own, 8'h4A, 6'h00, 6'h00, 1'b0, 5);
        $display("test refusals done");
        clr_seen <= 1'b0;
        write_cfg(1'b1, own, 8'h14, 6'h00, 6'h00, 1'b0, 8);
        check("algo clear seen", {32'h0, clr_seen}, 33'h1);
        $display("test algorithm clear done");
        hit = -1;
        @(posedge clk);
        xfs <= 1'b1;
        repeat (4) @(posedge clk);
        xfs <= 1'b0;
        for (int b = 0; b < 300 && hit < 0; b++) begin
            xbc <= 1'b1;
            repeat (4) @(posedge clk);
            xbc <= 1'b0;
            repeat (4) @(posedge clk);
            if (xia === 1'b1) hit = b;
        end
        check("x slot start", 33'(hit), {25'h0, sin[1], 2'b00});
        $display("test slot timing done");
        for (int k = 0; k < 2; k++) begin
            {cs, dl} = 2'($urandom);
            @(posedge clk);
            rstn <= 1'b0;
            mode <= 1'b0;
            straps <= (6'($urandom) & 6'h2D) | (k[0] ? 6'h12 : 6'h00);
            cfg_host_model_i.set_straps(cs, dl);
            repeat (6) @(posedge clk);
            rstn <= 1'b1;
            ctl[1] = {k[0], 1'b0, cs, 2'b00, straps[2], k[0], straps[0]};
            ctl[0] = {k[0], 1'b0, dl, 2'b00, straps[5], k[0], straps[3]};
            sin = '{6'h00, 6'h00};
            sout = '{6'h00, 6'h00};
            push_note();
        end
        $display("test strap mode done");
        close_out();
    end
endmodule // test_cfg_port
